// file: design/ebp_port_ctrl.sv
/*
  external expansion port control: read/write strobes, space selects, bus
  release and grant to an alternate master, or wait input and bus strobe.
  assumes an Avalon-MM master on ref_clk and asynchronous port pins.
*/
`timescale 1ns/100ps
module ebp_port_ctrl
  import ebp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        bus_request_n,
  input  wire logic        mode_select_a,
  input  wire logic        mode_select_b,
  output logic [15:0]      addr_o,
  output logic             addr_oe,
  output logic [23:0]      data_o,
  output logic             data_oe,
  input  wire logic [23:0] data_i,
  output logic             rd_n,
  output logic             wr_n,
  output logic             program_space_sel_n,
  output logic             data_space_sel_n,
  output logic             xy_sel,
  output logic             ctl_oe,
  output logic             bus_grant_n,
  output logic             bus_grant_oe,
  output logic             ext_int_req_a_n,
  output logic             ext_int_req_b_n
);
  // ****************************************
  // pin input stage
  // ****************************************
  ebp_sync_if sif ();

  ebp_pin_stage u_stage
  (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .bus_request_n (bus_request_n),
    .mode_select_a (mode_select_a),
    .mode_select_b (mode_select_b),
    .sif           (sif)
  );

  // ****************************************
  // state
  // ****************************************
  logic [7:0]  operating_mode_reg_q, operating_mode_reg_d;
  logic [15:0] acc_addr_q, acc_addr_d;
  logic [23:0] wdata_q, wdata_d;
  logic [23:0] rdata_q, rdata_d;
  logic [1:0]  irq_cfg_q, irq_cfg_d;
  logic        dir_q, dir_d;
  ebp_space_t  space_q, space_d;
  ebp_state_t  st_q, st_d;
  logic        rel_q, rel_d;
  logic        grant_q, grant_d;
  logic        ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic [15:0] addr_q, addr_d;
  logic [23:0] dout_q, dout_d;
  logic        doe_q, doe_d;
  logic        rd_q_n, rd_d_n;
  logic        wr_q_n, wr_d_n;
  logic        psel_q_n, psel_d_n;
  logic        dsel_q_n, dsel_d_n;
  logic        xy_q, xy_d;
  logic        own_q, own_d;
  logic        gpin_q_n, gpin_d_n;
  logic        live_q, live_d;
  logic        ext_int_req_a_n_q_n, ext_int_req_b_n_q_n;

  logic        arb_set;
  logic        req;
  logic        is_cmd;
  logic        stall;
  logic        active;
  logic [31:0] rd_mux;

  // ****************************************
  // bus slave decode
  // ****************************************
  always_comb
  begin
    arb_set = operating_mode_reg_q[EBP_CTRL_ARB_BIT];
    req     = avs_read | avs_write;
    is_cmd  = avs_write && avs_address == EBP_OFS_CMD;
    // a new access waits while one runs or the port is lent out
    stall   = is_cmd && (st_q != EBP_IDLE || rel_q || grant_q);
    ack_d   = req && !ack_q && !stall;
    avs_waitrequest = req && !ack_q;
    unique case (avs_address)
      EBP_OFS_CTRL:   rd_mux = {24'h000000, operating_mode_reg_q};
      EBP_OFS_ADDR:   rd_mux = {16'h0000, acc_addr_q};
      EBP_OFS_WDATA:  rd_mux = {8'h00, wdata_q};
      EBP_OFS_CMD:    rd_mux = {29'h00000000, space_q, dir_q};
      EBP_OFS_STATUS:
      begin
        rd_mux = 32'h00000000;
        rd_mux[EBP_ST_BUSY_BIT]  = st_q != EBP_IDLE;
        rd_mux[EBP_ST_GRANT_BIT] = grant_q;
        rd_mux[EBP_ST_MODEV_BIT] = live_q;
        rd_mux[EBP_ST_EXT_INT_REQ_A_N_BIT]  = sif.irq_act[0];
        rd_mux[EBP_ST_EXT_INT_REQ_B_N_BIT]  = sif.irq_act[1];
      end
      EBP_OFS_RDATA:  rd_mux = {8'h00, rdata_q};
      EBP_OFS_IRQ:    rd_mux = {30'h00000000, irq_cfg_q};
      default:        rd_mux = 32'h00000000;
    endcase
    rd_d = (avs_read && ack_d) ? rd_mux : rd_q;
  end

  // ****************************************
  // register writes
  // ****************************************
  logic wr_ok;

  always_comb
  begin
    wr_ok = avs_write && ack_d;
    operating_mode_reg_d = operating_mode_reg_q;
    acc_addr_d  = acc_addr_q;
    wdata_d     = wdata_q;
    irq_cfg_d   = irq_cfg_q;
    dir_d       = dir_q;
    space_d     = space_q;
    sif.irq_clr = 2'h0;
    sif.edge_sel = irq_cfg_q;
    live_d      = live_q | sif.mode_vld;
    if (sif.mode_vld)
    begin
      operating_mode_reg_d[EBP_CTRL_MODE_LSB +: 2] = sif.mode_val;
    end
    else if (wr_ok && avs_address == EBP_OFS_CTRL)
    begin
      operating_mode_reg_d = avs_writedata[7:0];
    end
    if (wr_ok && avs_address == EBP_OFS_ADDR)
    begin
      acc_addr_d = avs_writedata[15:0];
    end
    if (wr_ok && avs_address == EBP_OFS_WDATA)
    begin
      wdata_d = avs_writedata[23:0];
    end
    if (wr_ok && avs_address == EBP_OFS_IRQ)
    begin
      irq_cfg_d = {avs_writedata[EBP_IRQ_EDGE_B_BIT], avs_writedata[EBP_IRQ_EDGE_A_BIT]};
      sif.irq_clr = {avs_writedata[EBP_IRQ_CLR_B_BIT], avs_writedata[EBP_IRQ_CLR_A_BIT]};
    end
    if (wr_ok && is_cmd)
    begin
      dir_d   = avs_writedata[EBP_CMD_DIR_BIT];
      space_d = ebp_space_t'(avs_writedata[EBP_CMD_SPACE_LSB +: 2]);
    end
  end

  // ****************************************
  // access sequencer and arbitration
  // ****************************************
  always_comb
  begin
    st_d    = st_q;
    rel_d   = rel_q;
    grant_d = grant_q;
    rdata_d = rdata_q;
    unique case (st_q)
      EBP_IDLE:
      begin
        if (wr_ok && is_cmd)
        begin
          st_d = EBP_SETUP;
        end
      end
      EBP_SETUP:
      begin
        st_d = EBP_STROBE;
      end
      EBP_STROBE:
      begin
        // external party holds the access open with the wait input
        if (!(arb_set && !sif.req_n_s))
        begin
          st_d = EBP_DONE;
          if (!dir_q)
          begin
            rdata_d = data_i;
          end
        end
      end
      EBP_DONE:
      begin
        st_d = EBP_IDLE;
      end
    endcase
    // release only between accesses, grant one cycle after the float
    if (!arb_set && !sif.req_n_s && st_q == EBP_IDLE && !(wr_ok && is_cmd))
    begin
      rel_d   = 1'b1;
      grant_d = rel_q;
    end
    else
    begin
      rel_d   = 1'b0;
      grant_d = 1'b0;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  always_comb
  begin
    active   = st_d == EBP_SETUP || st_d == EBP_STROBE;
    own_d    = live_q && !rel_d;
    // address only moves when an access begins
    addr_d   = (st_q == EBP_IDLE && st_d == EBP_SETUP) ? acc_addr_q : addr_q;
    dout_d   = (st_d == EBP_SETUP) ? wdata_q : dout_q;
    doe_d    = own_d && !grant_d && active
               && dir_q_eff(st_q, dir_q, dir_d);
    rd_d_n   = !(st_d == EBP_STROBE && !dir_q);
    wr_d_n   = !(st_d == EBP_STROBE && dir_q);
    psel_d_n = !(active && space_d == EBP_SP_PROG);
    dsel_d_n = !(active && space_d != EBP_SP_PROG);
    xy_d     = active ? space_d == EBP_SP_X : xy_q;
    if (arb_set)
    begin
      gpin_d_n = !active;
    end
    else
    begin
      gpin_d_n = !grant_d;
    end
  end

  function automatic logic dir_q_eff(ebp_state_t s, logic dq, logic dd);
    dir_q_eff = (s == EBP_IDLE) ? dd : dq;
  endfunction

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      operating_mode_reg_q <= EBP_CTRL_RST;
      acc_addr_q <= EBP_ADDR_RST;
      wdata_q    <= EBP_DATA_RST;
      rdata_q    <= EBP_DATA_RST;
      irq_cfg_q  <= EBP_IRQC_RST;
      dir_q      <= 1'b0;
      space_q    <= EBP_SP_PROG;
      st_q       <= EBP_IDLE;
      rel_q      <= 1'b0;
      grant_q    <= 1'b0;
      ack_q      <= 1'b0;
      rd_q       <= 32'h00000000;
      addr_q     <= EBP_ADDR_RST;
      dout_q     <= EBP_DATA_RST;
      doe_q      <= 1'b0;
      rd_q_n     <= 1'b1;
      wr_q_n     <= 1'b1;
      psel_q_n   <= 1'b1;
      dsel_q_n   <= 1'b1;
      xy_q       <= 1'b0;
      own_q      <= 1'b0;
      gpin_q_n   <= 1'b1;
      live_q     <= 1'b0;
      ext_int_req_a_n_q_n   <= 1'b1;
      ext_int_req_b_n_q_n   <= 1'b1;
    end
    else
    begin
      operating_mode_reg_q <= operating_mode_reg_d;
      acc_addr_q <= acc_addr_d;
      wdata_q    <= wdata_d;
      rdata_q    <= rdata_d;
      irq_cfg_q  <= irq_cfg_d;
      dir_q      <= dir_d;
      space_q    <= space_d;
      st_q       <= st_d;
      rel_q      <= rel_d;
      grant_q    <= grant_d;
      ack_q      <= ack_d;
      rd_q       <= rd_d;
      addr_q     <= addr_d;
      dout_q     <= dout_d;
      doe_q      <= doe_d;
      rd_q_n     <= rd_d_n;
      wr_q_n     <= wr_d_n;
      psel_q_n   <= psel_d_n;
      dsel_q_n   <= dsel_d_n;
      xy_q       <= xy_d;
      own_q      <= own_d;
      gpin_q_n   <= gpin_d_n;
      live_q     <= live_d;
      ext_int_req_a_n_q_n   <= !sif.irq_act[0];
      ext_int_req_b_n_q_n   <= !sif.irq_act[1];
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // the port stays floating in reset and until the mode is latched
  assign avs_readdata        = rd_q;
  assign addr_o              = addr_q;
  assign addr_oe             = own_q;
  assign data_o              = dout_q;
  assign data_oe             = doe_q;
  assign rd_n                = rd_q_n;
  assign wr_n                = wr_q_n;
  assign program_space_sel_n = psel_q_n;
  assign data_space_sel_n    = dsel_q_n;
  assign xy_sel              = xy_q;
  assign ctl_oe              = own_q;
  assign bus_grant_n         = gpin_q_n;
  assign bus_grant_oe        = live_q;
  assign ext_int_req_a_n     = ext_int_req_a_n_q_n;
  assign ext_int_req_b_n     = ext_int_req_b_n_q_n;
endmodule

// file: common/ebp_pkg.sv
/*
  shared constants and types of the external bus port control block.
  assumes one 100 MHz clock and an Avalon-MM register bus with byte addresses.
*/
package ebp_pkg;
  // ****************************************
  // register map (byte offsets)
  // ****************************************
  localparam logic [4:0] EBP_OFS_CTRL   = 5'h00;
  localparam logic [4:0] EBP_OFS_ADDR   = 5'h04;
  localparam logic [4:0] EBP_OFS_WDATA  = 5'h08;
  localparam logic [4:0] EBP_OFS_CMD    = 5'h0c;
  localparam logic [4:0] EBP_OFS_STATUS = 5'h10;
  localparam logic [4:0] EBP_OFS_RDATA  = 5'h14;
  localparam logic [4:0] EBP_OFS_IRQ    = 5'h18;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int EBP_CTRL_ARB_BIT   = 7;
  localparam int EBP_CTRL_MODE_LSB  = 0;
  localparam int EBP_CMD_DIR_BIT    = 0;
  localparam int EBP_CMD_SPACE_LSB  = 1;
  localparam int EBP_IRQ_EDGE_A_BIT = 0;
  localparam int EBP_IRQ_EDGE_B_BIT = 1;
  localparam int EBP_IRQ_CLR_A_BIT  = 4;
  localparam int EBP_IRQ_CLR_B_BIT  = 5;
  localparam int EBP_ST_BUSY_BIT    = 0;
  localparam int EBP_ST_GRANT_BIT   = 1;
  localparam int EBP_ST_MODEV_BIT   = 2;
  localparam int EBP_ST_EXT_INT_REQ_A_N_BIT    = 3;
  localparam int EBP_ST_EXT_INT_REQ_B_N_BIT    = 4;
  localparam logic [7:0]  EBP_CTRL_RST  = 8'h00;
  localparam logic [15:0] EBP_ADDR_RST  = 16'h0000;
  localparam logic [23:0] EBP_DATA_RST  = 24'h000000;
  localparam logic [1:0]  EBP_IRQC_RST  = 2'h0;
  // cycles of the pin synchroniser before the mode pins may be latched
  localparam logic [1:0]  EBP_SYNC_LEN  = 2'h2;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0]
  {
    EBP_SP_PROG = 2'h0,
    EBP_SP_X    = 2'h1,
    EBP_SP_Y    = 2'h2
  } ebp_space_t;

  typedef enum logic [1:0]
  {
    EBP_IDLE   = 2'h0,
    EBP_SETUP  = 2'h1,
    EBP_STROBE = 2'h3,
    EBP_DONE   = 2'h2
  } ebp_state_t;
endpackage

// file: common/ebp_sync_if.sv
/*
  carrier between the port controller and its pin input stage.
  assumes both ends share ref_clk.
*/
`timescale 1ns/100ps
interface ebp_sync_if;
  logic       req_n_s;
  logic       mode_vld;
  logic [1:0] mode_val;
  logic [1:0] edge_sel;
  logic [1:0] irq_clr;
  logic [1:0] irq_act;

  modport stage
  (
    output req_n_s,
    output mode_vld,
    output mode_val,
    output irq_act,
    input  edge_sel,
    input  irq_clr
  );
  modport ctrl
  (
    input  req_n_s,
    input  mode_vld,
    input  mode_val,
    input  irq_act,
    output edge_sel,
    output irq_clr
  );
endinterface

// file: design/ebp_pin_stage.sv
/*
  pin input stage: synchronises request and mode/interrupt pins, latches the
  mode after reset release and detects level or falling-edge requests.
  assumes pins are asynchronous to ref_clk.
*/
`timescale 1ns/100ps
module ebp_pin_stage
  import ebp_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  input  wire logic  bus_request_n,
  input  wire logic  mode_select_a,
  input  wire logic  mode_select_b,
  ebp_sync_if.stage  sif
);
  // ****************************************
  // synchronisers
  // ****************************************
  logic [2:0] s1_q, s2_q, s1_d, s2_d;
  logic [1:0] prev_q, prev_d;
  logic [1:0] stick_q, stick_d;
  logic [1:0] cnt_q, cnt_d;
  logic       vld_q, vld_d;
  logic [1:0] pin_n;

  always_comb
  begin
    s1_d = {bus_request_n, mode_select_b, mode_select_a};
    s2_d = s1_q;
    pin_n = s2_q[1:0];
    prev_d = pin_n;
    // wait until the synchroniser holds post-release samples
    cnt_d = (cnt_q == EBP_SYNC_LEN) ? cnt_q : cnt_q + 2'h1;
    vld_d = (cnt_q == EBP_SYNC_LEN) && !vld_q;
  end

  // ****************************************
  // per-pin request detection
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_irq
      always_comb
      begin
        // a falling edge in the clear cycle still sets the flag; a low strap is no edge
        stick_d[g] = (vld_q & prev_q[g] & ~pin_n[g]) | (stick_q[g] & ~sif.irq_clr[g]);
        sif.irq_act[g] = (vld_q | cnt_q == EBP_SYNC_LEN) &
                         (sif.edge_sel[g] ? stick_q[g] : ~pin_n[g]);
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q    <= 3'h7;
      s2_q    <= 3'h7;
      prev_q  <= 2'h3;
      stick_q <= 2'h0;
      cnt_q   <= 2'h0;
      vld_q   <= 1'b0;
    end
    else
    begin
      s1_q    <= s1_d;
      s2_q    <= s2_d;
      prev_q  <= prev_d;
      stick_q <= stick_d;
      cnt_q   <= cnt_d;
      vld_q   <= vld_d | vld_q;
    end
  end

  assign sif.req_n_s  = s2_q[2];
  assign sif.mode_vld = vld_d;
  assign sif.mode_val = pin_n;
endmodule

// file: bench/ebp_port_ctrl_asserts.sv
/*
  concurrent checks on the pins of the port controller.
  assumes it is bound into ebp_port_ctrl and sees only its ports.
*/
`timescale 1ns/100ps
module ebp_port_ctrl_asserts
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        bus_request_n,
  input wire logic        mode_select_a,
  input wire logic [15:0] addr_o,
  input wire logic        addr_oe,
  input wire logic        data_oe,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        program_space_sel_n,
  input wire logic        data_space_sel_n,
  input wire logic        ctl_oe,
  input wire logic        bus_grant_n,
  input wire logic        ext_int_req_a_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_rd; !rd_n |-> ctl_oe && wr_n && !data_oe; endproperty
  a_rd: assert property (p_rd) else $error("read strobe without a driven read");
  property p_wr; !wr_n |-> ctl_oe && data_oe && rd_n && !(program_space_sel_n && data_space_sel_n);
  endproperty
  a_wr: assert property (p_wr) else $error("write strobe without driven data");
  // a release needs the pin low through both synchroniser stages
  property p_rel; $fell(ctl_oe) |-> !addr_oe && !data_oe && $past(bus_request_n, 2) == 1'b0;
  endproperty
  a_rel: assert property (p_rel) else $error("port released without request");
  property p_gnt; ($fell(bus_grant_n) && !ctl_oe) |-> $past(!ctl_oe && !addr_oe); endproperty
  a_gnt: assert property (p_gnt) else $error("grant before the port was released");
  property p_dflt; (!bus_grant_n && !ctl_oe) |-> !data_oe && !addr_oe; endproperty
  a_dflt: assert property (p_dflt) else $error("data bus driven while granted");
  property p_ahold; $changed(addr_o) |-> !(program_space_sel_n && data_space_sel_n); endproperty
  a_ahold: assert property (p_ahold) else $error("address moved without access");
  property p_sel; !program_space_sel_n |-> data_space_sel_n; endproperty
  a_sel: assert property (p_sel) else $error("program and data select together");
  property p_irq; $fell(ext_int_req_a_n) |->
    !($past(mode_select_a, 2) && $past(mode_select_a, 3) && $past(mode_select_a, 4)); endproperty
  a_irq: assert property (p_irq) else $error("request a without a low pin");
endmodule

bind ebp_port_ctrl ebp_port_ctrl_asserts u_asserts (.ref_clk, .rst_n, .bus_request_n,
  .mode_select_a, .addr_o, .addr_oe, .data_oe, .rd_n, .wr_n, .program_space_sel_n,
  .data_space_sel_n, .ctl_oe, .bus_grant_n, .ext_int_req_a_n);

// file: bench/ebp_mem_model.sv
/*
  external program and x/y data memories on the expansion port pins.
  assumes the controller drives data only while writing.
*/
`timescale 1ns/100ps
module ebp_mem_model
(
  input  wire logic        ref_clk,
  input  wire logic [15:0] addr_o,
  input  wire logic [23:0] data_o,
  input  wire logic        data_oe,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        program_space_sel_n,
  input  wire logic        data_space_sel_n,
  input  wire logic        xy_sel,
  input  wire logic        ctl_oe,
  output logic      [23:0] data_i
);
  logic [23:0] mem [0:47];
  logic [23:0] last_q = 24'h000000;
  logic [5:0]  idx;
  logic        sel;

  assign sel = !program_space_sel_n || !data_space_sel_n;
  assign idx = {!program_space_sel_n ? 2'h0 : (xy_sel ? 2'h1 : 2'h2), addr_o[3:0]};

  always @(posedge ref_clk)
  begin
    if (ctl_oe && sel && data_oe && !wr_n)
      mem[idx] <= data_o;
    if (ctl_oe && sel && !rd_n)
      last_q <= mem[idx];
  end

  // an undriven bus shows the inverse of the last value so stale data never matches
  always_comb data_i = (ctl_oe && sel && !rd_n) ? mem[idx] : ~last_q;
endmodule

// file: bench/testbench.sv
/*
  self-checking bench of the port controller with a memory model on its pins.
  assumes the design, the checker and the model are compiled first.
*/
`timescale 1ns/100ps
module testbench;
  import ebp_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        bus_request_n = 1'b1;  // pulled up while unused
  logic [1:0]  mp = 2'h3;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] addr_o;
  logic [23:0] data_o;
  logic [23:0] data_i;
  logic        addr_oe, data_oe, rd_n, wr_n, ctl_oe, xy_sel;
  logic        program_space_sel_n, data_space_sel_n;
  logic        bus_grant_n, bus_grant_oe, ext_int_req_a_n, ext_int_req_b_n;
  logic [23:0] shd [0:47];
  logic [31:0] seed = 32'h2d;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          stb_n = 0;
  logic        bs_seen = 1'b0;

  ebp_port_ctrl dut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .bus_request_n, .mode_select_a(mp[0]),
    .mode_select_b(mp[1]), .addr_o, .addr_oe, .data_o, .data_oe, .data_i, .rd_n, .wr_n,
    .program_space_sel_n, .data_space_sel_n, .xy_sel, .ctl_oe, .bus_grant_n, .bus_grant_oe,
    .ext_int_req_a_n, .ext_int_req_b_n);
  ebp_mem_model mem (.ref_clk, .addr_o, .data_o, .data_oe, .rd_n, .wr_n, .program_space_sel_n,
    .data_space_sel_n, .xy_sel, .ctl_oe, .data_i);

  always #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (!rd_n)
      stb_n <= stb_n + 1;
    if (!wr_n && !bus_grant_n)
      bs_seen <= 1'b1;
    if (cyc == 20000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task end_of_test();
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // the answer is taken at the rising edge that samples waitrequest low
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
      @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(a, 1'b0, 32'h0, q);
  endtask

  task automatic acc(input logic [1:0] sp, input logic w, input logic [15:0] a,
                     input logic [23:0] d);
    logic [31:0] q;
    wr(EBP_OFS_ADDR, {16'h0, a});
    if (w)
      wr(EBP_OFS_WDATA, {8'h0, d});
    wr(EBP_OFS_CMD, {29'h0, sp, w});
    for (int n = 0; n < 40; n++)
    begin
      rd(EBP_OFS_STATUS, q);
      if (q[EBP_ST_BUSY_BIT] === 1'b0)
        break;
    end
    if (w)
      shd[{sp, a[3:0]}] = d;
    else
    begin
      rd(EBP_OFS_RDATA, q);
      chk(q, {8'h0, shd[{sp, a[3:0]}]});
    end
  endtask

  task automatic do_reset(input logic [1:0] m);
    logic [31:0] q;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    mp <= m;  // straps held through reset
    repeat (10) @(posedge ref_clk);
    chk(32'({ctl_oe, addr_oe, data_oe, bus_grant_oe}), 32'h0);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    mp <= 2'h3;
    rd(EBP_OFS_STATUS, q);
    chk(32'(q[EBP_ST_MODEV_BIT]), 32'h1);
    rd(EBP_OFS_CTRL, q);
    chk(q, {30'h0, m});
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [31:0] q;
    logic [1:0]  sp;
    int          stb0;
    do_reset(2'h2);
    rd(5'h1c, q);
    chk(q, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      q = rnd();
      sp = q[1:0] % 2'h3;
      acc(sp, 1'b1, q[31:16], q[23:0]);
      acc((sp == 2'h2) ? 2'h0 : sp + 2'h1, 1'b1, q[31:16], ~q[23:0]);
      acc(sp, 1'b0, q[31:16], 24'h0);
    end
    wr(EBP_OFS_CTRL, 32'h81);
    rd(EBP_OFS_CTRL, q);
    chk(q, 32'h81);
    acc(2'h1, 1'b1, 16'h0005, 24'h5a5a5a);
    chk(32'(bs_seen), 32'h1);
    stb0 = stb_n;
    bus_request_n <= 1'b0;
    fork
      begin
        repeat (12) @(posedge ref_clk);
        bus_request_n <= 1'b1;
      end
    join_none
    acc(2'h1, 1'b0, 16'h0005, 24'h0);
    chk(32'(stb_n - stb0 > 2), 32'h1);
    wr(EBP_OFS_CTRL, 32'h0);
    bus_request_n <= 1'b0;
    for (int n = 0; n < 20 && bus_grant_n !== 1'b0; n++)
      @(negedge ref_clk);
    chk(32'({bus_grant_n, ctl_oe, addr_oe, data_oe}), 32'h0);
    rd(EBP_OFS_STATUS, q);
    chk(32'(q[EBP_ST_GRANT_BIT]), 32'h1);
    bus_request_n <= 1'b1;
    repeat (6) @(negedge ref_clk);
    chk(32'({bus_grant_n, ctl_oe}), 32'h3);
    wr(EBP_OFS_IRQ, 32'h0);
    mp <= 2'h2;
    repeat (5) @(negedge ref_clk);
    chk(32'({ext_int_req_b_n, ext_int_req_a_n}), 32'h2);
    wr(EBP_OFS_IRQ, 32'h3);
    mp <= 2'h1;
    repeat (2) @(posedge ref_clk);
    mp <= 2'h3;
    repeat (5) @(negedge ref_clk);
    chk(32'(ext_int_req_b_n), 32'h0);
    wr(EBP_OFS_IRQ, 32'h33);
    repeat (4) @(negedge ref_clk);
    chk(32'({ext_int_req_b_n, ext_int_req_a_n}), 32'h3);
    do_reset(2'h1);
    acc(2'h2, 1'b1, 16'h00a3, 24'hc3c3c3);
    acc(2'h2, 1'b0, 16'h00a3, 24'h0);
    end_of_test();
  end
endmodule
